//--- src/smo_clamp.v
`timescale 1ns/1ps
// Returns the smallest of a magnitude and two unsigned ceilings.
module smo_clamp #(
  parameter W = 32
) (
  input  wire [W-1:0] val,
  input  wire [W-1:0] lim_a,
  input  wire [W-1:0] lim_b,
  output wire [W-1:0] out
);
  wire [W-1:0] lim;  // Tighter of the two ceilings.

  assign lim = (lim_a < lim_b) ? lim_a : lim_b;
  assign out = (val > lim) ? lim : val;
endmodule

//--- src/smo_regs.vh
`ifndef SMO_REGS_VH
`define SMO_REGS_VH

// Register byte offsets on the APB bus.
`define SMO_OFF_CTRL       8'h00
`define SMO_OFF_MODE       8'h04
`define SMO_OFF_IP_POS     8'h08
`define SMO_OFF_IP_TCONST  8'h0c
`define SMO_OFF_IP_TIDX    8'h10
`define SMO_OFF_STATUS     8'h14
`define SMO_OFF_MODE_DISP  8'h18
`define SMO_OFF_POS_ACT    8'h1c
`define SMO_OFF_VEL_ACT    8'h20
`define SMO_OFF_TGT_VEL    8'h24
`define SMO_OFF_PROF_ACC   8'h28
`define SMO_OFF_PROF_DEC   8'h2c
`define SMO_OFF_MAX_VEL    8'h30
`define SMO_OFF_MAX_ACC    8'h34
`define SMO_OFF_MAX_DEC    8'h38
`define SMO_OFF_POS_WIN    8'h3c
`define SMO_OFF_POS_WTIME  8'h40
`define SMO_OFF_SWL_EN     8'h44
`define SMO_OFF_MIN_LIM    8'h48
`define SMO_OFF_MAX_LIM    8'h4c
`define SMO_OFF_CONV       8'h50
`define SMO_OFF_MAP_BASE   8'h60
`define SMO_MAP_WORDS      7

// Mapping entry layout: index, subindex, length in bits.
`define SMO_MAP_IDX_MSB    31
`define SMO_MAP_IDX_LSB    16
`define SMO_MAP_SUB_MSB    15
`define SMO_MAP_SUB_LSB    8
`define SMO_MAP_LEN_MSB    7
`define SMO_MAP_LEN_LSB    0

// Fixed mapping entries of the four process data objects.
`define SMO_MAP_RX1_CW     32'h60400010
`define SMO_MAP_RX1_MODE   32'h60600008
`define SMO_MAP_RX2_IPPOS  32'h60c10020
`define SMO_MAP_TX1_SW     32'h60410010
`define SMO_MAP_TX1_MDISP  32'h60610008
`define SMO_MAP_TX2_POS    32'h60640020
`define SMO_MAP_TX2_VEL    32'h606c0020

// Mode and control word codes.
`define SMO_MODE_IP        8'h07
`define SMO_MODE_PV        8'h03
`define SMO_CW_READY       16'h0006
`define SMO_CW_SWON        16'h0007
`define SMO_CW_OPEN        16'h000f
`define SMO_CW_IPRUN       16'h001f

// Status word codes and bits.
`define SMO_SW_READY       16'h0231
`define SMO_SW_SWON        16'h0233
`define SMO_SW_OPEN        16'h0237
`define SMO_SW_IDLE        16'h0250
`define SMO_SW_BIT_REACH   10
`define SMO_SW_BIT_LIMIT   11
`define SMO_SW_BIT_IPACT   12

// Reset values, plus the accepted 10 ms time index and the conversion shift.
`define SMO_RST_TCONST     8'h01
`define SMO_RST_TIDX       8'hfd
`define SMO_TIDX_10MS      8'hfe
`define SMO_RST_MAX_VEL    32'h7fffffff
`define SMO_RST_MAX_ACC    32'h7fffffff
`define SMO_RST_PROF_ACC   32'h0a6aaaaa
`define SMO_RST_MAX_LIM    32'h7fffffff
`define SMO_RST_MIN_LIM    32'h80000000
`define SMO_RST_CONV       16'h0100
`define SMO_CONV_SHIFT     8

// Timing: one millisecond in clock cycles at 50 ns.
`define SMO_CLK_NS         50
`define SMO_MS_NS          1000000
`define SMO_MS_CYCLES      (`SMO_MS_NS / `SMO_CLK_NS)

`endif

//--- src/smo_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin inputs.
module smo_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;  // First stage, read only by the second.
  reg [W-1:0] sync_q;  // Second stage, safe to use.

  // Both stages clear on reset and hold while the enable is low.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

//--- src/smo_top.v
// Behaviour
// - First receive map: control word, then mode.
// - Second receive map: one 32-bit interpolation target.
// - First transmit map: status word, mode display.
// - Second transmit map: actual position, actual velocity.
// - Mode seven selects interpolated position mode.
// - Time constant ten when stopped: 10 ms.
// - Interpolation targets are absolute positions only.
// - Time index resets to -3, accepts -2.
// - Control 6 gives 0x0231, 7 gives 0x0233.
// - Control 15: reached and limit bits added.
// - Control 31 also adds interpolation-active bit.
// - Reached only inside window for window time.
// - Velocity ramps smoothly by acceleration and deceleration.
// - References limited, then converted to encoder units.
// - Software limit off until enable written one.
// - Limit hit: stop, warn, set status bit 11.
// - Reverse command leaves limit, clears bit 11.
// - External switch overrides software limit for overtravel.
// - Target velocity clamped to both maximum speeds.
// - Profile ramps clamped to maximum acceleration, deceleration.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "smo_regs.vh"
module smo_top #(
  parameter        MS_CYCLES     = `SMO_MS_CYCLES,  // Clock cycles per millisecond.
  parameter [31:0] MOTOR_MAX_VEL = 32'h00100000     // Motor top speed, reference units.
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sync_pin,
  input  wire        dlim_pos_pin,
  input  wire        dlim_neg_pin,
  input  wire [31:0] pos_fb,
  input  wire [31:0] vel_fb,
  output reg  [31:0] vel_cmd_q,
  output reg  [31:0] pos_cmd_q,
  output reg         ip_active_q,
  output reg         overtravel_q,
  output reg         motor_stop_q
);
  // Host-written objects.
  reg  [15:0] ctrl_q;         // Control word.
  reg  [7:0]  mode_q;         // Operation mode.
  reg  [31:0] ip_tgt_q;       // Latest interpolation target, absolute.
  reg  [7:0]  tconst_q;       // Interpolation time constant in ms.
  reg  [7:0]  tidx_q;         // Interpolation time index, signed.
  reg  [31:0] tgt_vel_q;      // Target velocity, signed, reference units.
  reg  [31:0] prof_acc_q;     // Profile acceleration per ms.
  reg  [31:0] prof_dec_q;     // Profile deceleration per ms.
  reg  [31:0] max_vel_q;      // User maximum velocity.
  reg  [31:0] max_acc_q;      // User maximum acceleration.
  reg  [31:0] max_dec_q;      // User maximum deceleration.
  reg  [31:0] pos_win_q;      // Position window.
  reg  [15:0] pos_wtime_q;    // Position window time in ms.
  reg         swl_en_q;       // Software limit enable.
  reg  [31:0] min_lim_q;      // Lower software position limit.
  reg  [31:0] max_lim_q;      // Upper software position limit.
  reg  [15:0] conv_q;         // Reference to encoder factor, 8 fraction bits.
  // Internal state.
  reg  [15:0] status_q;       // Status word as last computed.
  reg  [31:0] vel_ref_q;      // Ramped velocity, reference units.
  reg  [31:0] ip_latch_q;     // Target taken at the last SYNC.
  reg  [31:0] ms_cnt_q;       // Millisecond prescaler.
  reg  [7:0]  ip_cnt_q;       // Milliseconds into the interpolation period.
  reg  [15:0] win_cnt_q;      // Milliseconds spent inside the window.
  reg         reached_q;      // Target reached flag.
  reg         swl_hit_q;      // Software limit state.
  reg         swl_dir_q;      // Direction of the hit, one for positive.
  reg         sync_d1_q;      // Previous synchronised SYNC level.
  // Synchronised pins.
  wire        sync_s;
  wire        dlp_s;
  wire        dln_s;
  // Bus decode.
  wire        acc_ph;
  wire        wr_en;
  // Derived terms.
  wire        ms_tick;
  wire        ip_sel;
  wire        ip_run;
  wire        stopped;
  wire        sync_rise;
  wire [31:0] vel_mag;
  wire [31:0] vel_lim;
  wire [31:0] tgt_clamp;
  wire [31:0] acc_lim;
  wire [31:0] dec_lim;
  wire [31:0] pos_err;
  wire [31:0] pos_err_abs;
  wire [47:0] vel_enc;
  wire [47:0] pos_enc;
  wire        ext_any;
  wire        lim_warn;
  reg  [31:0] map_word;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  // Pin inputs pass two flip-flops before use.
  smo_sync #(.W(3)) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .din     ({sync_pin, dlim_pos_pin, dlim_neg_pin}),
    .dout    ({sync_s, dlp_s, dln_s})
  );

  // Target velocity magnitude is held under both ceilings.
  assign vel_mag = tgt_vel_q[31] ? (~tgt_vel_q + 32'h00000001) : tgt_vel_q;
  smo_clamp #(.W(32)) u_vclamp (
    .val   (vel_mag),
    .lim_a (max_vel_q),
    .lim_b (MOTOR_MAX_VEL),
    .out   (vel_lim)
  );
  assign tgt_clamp = tgt_vel_q[31] ? (~vel_lim + 32'h00000001) : vel_lim;

  // Ramp rates are held under the user maxima.
  smo_clamp #(.W(32)) u_aclamp (
    .val   (prof_acc_q),
    .lim_a (max_acc_q),
    .lim_b (max_acc_q),
    .out   (acc_lim)
  );
  smo_clamp #(.W(32)) u_dclamp (
    .val   (prof_dec_q),
    .lim_a (max_dec_q),
    .lim_b (max_dec_q),
    .out   (dec_lim)
  );

  // APB access phase; every access waits one cycle for pready.
  assign acc_ph  = psel & penable & ~pready;
  assign wr_en   = psel & penable & pready & pwrite & ~pslverr;

  // Mode decode and motion gating.
  assign ms_tick   = (ms_cnt_q == (MS_CYCLES - 1));
  assign ip_sel    = (mode_q == `SMO_MODE_IP);
  assign ip_run    = ip_sel & (ctrl_q == `SMO_CW_IPRUN);
  assign stopped   = (vel_ref_q == 32'h00000000) & ~ip_run;
  assign sync_rise = sync_s & ~sync_d1_q;

  // Position error against the commanded target, as a magnitude.
  assign pos_err     = ip_latch_q - pos_fb;
  assign pos_err_abs = pos_err[31] ? (~pos_err + 32'h00000001) : pos_err;

  // Conversion to encoder units happens after limiting.
  assign vel_enc = $signed(vel_ref_q) * $signed({16'h0000, conv_q});
  assign pos_enc = $signed(ip_latch_q) * $signed({16'h0000, conv_q});

  // External switches decide overtravel whenever either is active.
  assign ext_any  = dlp_s | dln_s;
  assign lim_warn = ext_any ? 1'b1 : swl_hit_q;

  // Read-only mapping table, one entry per word.
  always @* begin
    case (paddr[4:2])
      3'd0:    map_word = `SMO_MAP_RX1_CW;
      3'd1:    map_word = `SMO_MAP_RX1_MODE;
      3'd2:    map_word = `SMO_MAP_RX2_IPPOS;
      3'd3:    map_word = `SMO_MAP_TX1_SW;
      3'd4:    map_word = `SMO_MAP_TX1_MDISP;
      3'd5:    map_word = `SMO_MAP_TX2_POS;
      3'd6:    map_word = `SMO_MAP_TX2_VEL;
      default: map_word = 32'h00000000;
    endcase
  end

  // Read multiplexer; narrow objects sit in the low bits.
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `SMO_OFF_CTRL:      rd_mux = {16'h0000, ctrl_q};
      `SMO_OFF_MODE:      rd_mux = {24'h000000, mode_q};
      `SMO_OFF_IP_POS:    rd_mux = ip_tgt_q;
      `SMO_OFF_IP_TCONST: rd_mux = {24'h000000, tconst_q};
      `SMO_OFF_IP_TIDX:   rd_mux = {24'h000000, tidx_q};
      `SMO_OFF_STATUS:    rd_mux = {16'h0000, status_q};
      `SMO_OFF_MODE_DISP: rd_mux = {24'h000000, mode_q};
      `SMO_OFF_POS_ACT:   rd_mux = pos_fb;
      `SMO_OFF_VEL_ACT:   rd_mux = vel_fb;
      `SMO_OFF_TGT_VEL:   rd_mux = tgt_vel_q;
      `SMO_OFF_PROF_ACC:  rd_mux = prof_acc_q;
      `SMO_OFF_PROF_DEC:  rd_mux = prof_dec_q;
      `SMO_OFF_MAX_VEL:   rd_mux = max_vel_q;
      `SMO_OFF_MAX_ACC:   rd_mux = max_acc_q;
      `SMO_OFF_MAX_DEC:   rd_mux = max_dec_q;
      `SMO_OFF_POS_WIN:   rd_mux = pos_win_q;
      `SMO_OFF_POS_WTIME: rd_mux = {16'h0000, pos_wtime_q};
      `SMO_OFF_SWL_EN:    rd_mux = {31'h00000000, swl_en_q};
      `SMO_OFF_MIN_LIM:   rd_mux = min_lim_q;
      `SMO_OFF_MAX_LIM:   rd_mux = max_lim_q;
      `SMO_OFF_CONV:      rd_mux = {16'h0000, conv_q};
      default: begin
        // The mapping table occupies a block of seven words.
        if ((paddr >= `SMO_OFF_MAP_BASE) && (paddr[1:0] == 2'b00) &&
            (paddr < (`SMO_OFF_MAP_BASE + 8'h1c))) begin
          rd_mux = map_word;
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Bus handshake: pready rises one cycle into the access phase.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready <= acc_ph;
      if (acc_ph) begin
        // Unmapped addresses, and writes to read-only words, flag an error.
        pslverr <= ~rd_hit | (pwrite & ((paddr == `SMO_OFF_STATUS) |
                   (paddr == `SMO_OFF_MODE_DISP) | (paddr == `SMO_OFF_POS_ACT) |
                   (paddr == `SMO_OFF_VEL_ACT) | (paddr >= `SMO_OFF_MAP_BASE)));
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Register writes land on the edge that completes the transfer.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q      <= 16'h0000;
      mode_q      <= 8'h00;
      ip_tgt_q    <= 32'h00000000;
      tconst_q    <= `SMO_RST_TCONST;
      tidx_q      <= `SMO_RST_TIDX;
      tgt_vel_q   <= 32'h00000000;
      prof_acc_q  <= `SMO_RST_PROF_ACC;
      prof_dec_q  <= `SMO_RST_PROF_ACC;
      max_vel_q   <= `SMO_RST_MAX_VEL;
      max_acc_q   <= `SMO_RST_MAX_ACC;
      max_dec_q   <= `SMO_RST_MAX_ACC;
      pos_win_q   <= 32'h00000000;
      pos_wtime_q <= 16'h0000;
      swl_en_q    <= 1'b0;
      min_lim_q   <= `SMO_RST_MIN_LIM;
      max_lim_q   <= `SMO_RST_MAX_LIM;
      conv_q      <= `SMO_RST_CONV;
    end else if (ce && wr_en) begin
      case (paddr)
        `SMO_OFF_CTRL:      ctrl_q <= pwdata[15:0];
        `SMO_OFF_MODE:      mode_q <= pwdata[7:0];
        // Stored as given: the value is an absolute target, never an offset.
        `SMO_OFF_IP_POS:    ip_tgt_q <= pwdata;
        `SMO_OFF_IP_TCONST: begin
          // The period may only change while the drive is stopped.
          if (stopped) begin
            tconst_q <= pwdata[7:0];
          end
        end
        `SMO_OFF_IP_TIDX: begin
          // Only the two supported indices are accepted.
          if ((pwdata[7:0] == `SMO_TIDX_10MS) || (pwdata[7:0] == `SMO_RST_TIDX)) begin
            tidx_q <= pwdata[7:0];
          end
        end
        `SMO_OFF_TGT_VEL:   tgt_vel_q <= pwdata;
        `SMO_OFF_PROF_ACC:  prof_acc_q <= pwdata;
        `SMO_OFF_PROF_DEC:  prof_dec_q <= pwdata;
        `SMO_OFF_MAX_VEL:   max_vel_q <= pwdata;
        `SMO_OFF_MAX_ACC:   max_acc_q <= pwdata;
        `SMO_OFF_MAX_DEC:   max_dec_q <= pwdata;
        `SMO_OFF_POS_WIN:   pos_win_q <= pwdata;
        `SMO_OFF_POS_WTIME: pos_wtime_q <= pwdata[15:0];
        `SMO_OFF_SWL_EN:    swl_en_q <= pwdata[0];
        `SMO_OFF_MIN_LIM:   min_lim_q <= pwdata;
        `SMO_OFF_MAX_LIM:   max_lim_q <= pwdata;
        `SMO_OFF_CONV:      conv_q <= pwdata[15:0];
        default: begin
          // Read-only and unmapped words ignore writes.
        end
      endcase
    end
  end

  // Millisecond prescaler and interpolation period counter.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ms_cnt_q  <= 32'h00000000;
      ip_cnt_q  <= 8'h00;
      sync_d1_q <= 1'b0;
    end else if (ce) begin
      sync_d1_q <= sync_s;
      ms_cnt_q  <= ms_tick ? 32'h00000000 : (ms_cnt_q + 32'h00000001);
      if (!ip_run) begin
        ip_cnt_q <= 8'h00;
      end else if (ms_tick) begin
        // Wrap after the programmed number of milliseconds.
        ip_cnt_q <= (ip_cnt_q + 8'h01 >= tconst_q) ? 8'h00 : (ip_cnt_q + 8'h01);
      end
    end
  end

  // Interpolation target: taken at SYNC, applied at each period boundary.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ip_latch_q <= 32'h00000000;
      pos_cmd_q  <= 32'h00000000;
    end else if (ce) begin
      // The host clocks targets in with SYNC; no SYNC, no new target.
      if (ip_run && sync_rise && !lim_warn) begin
        ip_latch_q <= ip_tgt_q;
      end
      if (ip_run && ms_tick && (ip_cnt_q == 8'h00)) begin
        pos_cmd_q <= pos_enc[31+`SMO_CONV_SHIFT:`SMO_CONV_SHIFT];
      end
    end
  end

  // Velocity planner: one ramp step per millisecond toward the clamped target.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      vel_ref_q <= 32'h00000000;
      vel_cmd_q <= 32'h00000000;
    end else if (ce) begin
      vel_cmd_q <= vel_enc[31+`SMO_CONV_SHIFT:`SMO_CONV_SHIFT];
      if (lim_warn || ip_sel || (ctrl_q[3:0] != 4'hf)) begin
        vel_ref_q <= 32'h00000000;
      end else if (ms_tick) begin
        // Rising magnitude uses acceleration, falling uses deceleration.
        if ($signed(vel_ref_q) < $signed(tgt_clamp)) begin
          if ($signed(vel_ref_q) >= 0) begin
            vel_ref_q <= ($signed(tgt_clamp - vel_ref_q) > $signed(acc_lim) &&
                          acc_lim[31] == 1'b0) ? vel_ref_q + acc_lim : tgt_clamp;
          end else begin
            vel_ref_q <= ($signed(tgt_clamp - vel_ref_q) > $signed(dec_lim) &&
                          dec_lim[31] == 1'b0) ? vel_ref_q + dec_lim : tgt_clamp;
          end
        end else if ($signed(vel_ref_q) > $signed(tgt_clamp)) begin
          if ($signed(vel_ref_q) <= 0) begin
            vel_ref_q <= ($signed(vel_ref_q - tgt_clamp) > $signed(acc_lim) &&
                          acc_lim[31] == 1'b0) ? vel_ref_q - acc_lim : tgt_clamp;
          end else begin
            vel_ref_q <= ($signed(vel_ref_q - tgt_clamp) > $signed(dec_lim) &&
                          dec_lim[31] == 1'b0) ? vel_ref_q - dec_lim : tgt_clamp;
          end
        end
      end
    end
  end

  // Software limit: set on reaching either bound, cleared by a reverse command.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      swl_hit_q <= 1'b0;
      swl_dir_q <= 1'b0;
    end else if (ce) begin
      if (!swl_en_q) begin
        swl_hit_q <= 1'b0;
      end else if (swl_hit_q) begin
        // A command pointing back inside releases the limit state.
        if (swl_dir_q ? (ip_sel ? ($signed(ip_tgt_q) < $signed(pos_fb)) : tgt_vel_q[31])
                      : (ip_sel ? ($signed(ip_tgt_q) > $signed(pos_fb))
                                : (~tgt_vel_q[31] & (tgt_vel_q != 32'h00000000)))) begin
          swl_hit_q <= 1'b0;
        end
      end else if ($signed(pos_fb) >= $signed(max_lim_q)) begin
        swl_hit_q <= 1'b1;
        swl_dir_q <= 1'b1;
      end else if ($signed(pos_fb) <= $signed(min_lim_q)) begin
        swl_hit_q <= 1'b1;
        swl_dir_q <= 1'b0;
      end
    end
  end

  // Target reached: error inside the window for the full window time.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      win_cnt_q <= 16'h0000;
      reached_q <= 1'b0;
    end else if (ce) begin
      if (pos_err_abs > pos_win_q) begin
        win_cnt_q <= 16'h0000;
        reached_q <= 1'b0;
      end else begin
        if (ms_tick && (win_cnt_q != 16'hffff)) begin
          win_cnt_q <= win_cnt_q + 16'h0001;
        end
        reached_q <= (win_cnt_q >= pos_wtime_q);
      end
    end
  end

  // Status word and motion outputs.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q     <= `SMO_SW_IDLE;
      ip_active_q  <= 1'b0;
      overtravel_q <= 1'b0;
      motor_stop_q <= 1'b1;
    end else if (ce) begin
      ip_active_q  <= ip_run;
      overtravel_q <= ext_any ? 1'b1 : swl_hit_q;
      motor_stop_q <= lim_warn | (ctrl_q[3:0] != 4'hf);
      case (ctrl_q)
        `SMO_CW_READY: status_q <= `SMO_SW_READY;
        `SMO_CW_SWON:  status_q <= `SMO_SW_SWON;
        `SMO_CW_OPEN,
        `SMO_CW_IPRUN: begin
          status_q <= `SMO_SW_OPEN;
          status_q[`SMO_SW_BIT_REACH] <= reached_q;
          status_q[`SMO_SW_BIT_LIMIT] <= swl_hit_q;
          status_q[`SMO_SW_BIT_IPACT] <= ip_run;
        end
        default:       status_q <= `SMO_SW_IDLE;
      endcase
    end
  end

endmodule

//--- tb/smo_chk_sva.sv
`timescale 1ns/1ps
// Port-level checker for the motion block.
module smo_chk (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        dlim_pos_pin,
  input wire        ip_active_q,
  input wire        overtravel_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A read of one address in its access phase.
  sequence s_rd(a);
    psel && penable && !pwrite && paddr == a && pready;
  endsequence
  // The limit pin held long enough to pass the synchroniser.
  sequence s_pin_held;
    (dlim_pos_pin && ce)[*4];
  endsequence
  property p_pulse; pready |=> !pready; endproperty
  property p_answer; psel && penable && !pready && ce |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rst; $rose(rst_n) |-> !ip_active_q && !overtravel_q; endproperty
  property p_rx1; s_rd(8'h60) |-> prdata == 32'h60400010; endproperty
  property p_rx2; s_rd(8'h68) |-> prdata == 32'h60c10020; endproperty
  property p_tx1; s_rd(8'h6c) |-> prdata == 32'h60410010; endproperty
  property p_ext; s_pin_held |-> ##[0:1] overtravel_q; endproperty
  property p_ip;
    $rose(ip_active_q) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_answer: assert property (p_answer) else $error("no answer after one wait state");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_rst: assert property (p_rst) else $error("outputs active right after reset");
  a_rx1: assert property (p_rx1) else $error("first receive map word wrong");
  a_rx2: assert property (p_rx2) else $error("second receive map word wrong");
  a_tx1: assert property (p_tx1) else $error("first transmit map word wrong");
  a_ext: assert property (p_ext) else $error("limit switch not reported");
  a_ip: assert property (p_ip) else $error("motion started without a write");
endmodule
bind smo_top smo_chk u_chk (.sys_clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .dlim_pos_pin, .ip_active_q, .overtravel_q);

//--- tb/smo_host.sv
`timescale 1ns/1ps
// Host side: sends SYNC pulses on request and drives the limit switch.
module smo_host (
  input  wire sys_clk,
  input  wire fire,
  input  wire lim,
  output reg  sync_pin = 1'b0,
  output reg  dlim_pos_pin = 1'b0
);
  reg [1:0] cnt_q = 2'd0;  // Remaining cycles of the SYNC pulse.
  // A SYNC pulse is four cycles wide; the bench keeps them 1 to 20 ms apart.
  always @(posedge sys_clk) begin
    dlim_pos_pin <= lim;
    cnt_q <= fire ? 2'd3 : (cnt_q != 2'd0 ? cnt_q - 2'd1 : 2'd0);
    sync_pin <= fire || cnt_q != 2'd0;
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`include "smo_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb;
  localparam MS = 20;
  reg        sys_clk, rst_n, psel, penable, pwrite, fire, lim, er;
  reg [7:0]  paddr;
  reg [31:0] pwdata, pos_fb, vel_fb, rd, tgt;
  wire [31:0] prdata, vel_cmd_q, pos_cmd_q;
  wire       pready, pslverr, sync_pin, dlim_pos_pin, ip_active_q, overtravel_q, motor_stop_q;
  int        fail_count, checked, n;
  time       t0 = 0;  // Time of the previous position command update.
  int unsigned map_q[$] = '{32'h60400010, 32'h60600008, 32'h60c10020, 32'h60410010,
    32'h60610008, 32'h60640020, 32'h606c0020};  // Expected mapping words.
  smo_top #(.MS_CYCLES(MS), .MOTOR_MAX_VEL(32'h600)) u_smo_top (.sys_clk(sys_clk),
    .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_pin(sync_pin), .dlim_pos_pin(dlim_pos_pin), .dlim_neg_pin(1'b0),
    .pos_fb(pos_fb), .vel_fb(vel_fb), .vel_cmd_q(vel_cmd_q), .pos_cmd_q(pos_cmd_q),
    .ip_active_q(ip_active_q), .overtravel_q(overtravel_q), .motor_stop_q(motor_stop_q));
  smo_host u_smo_host (.sys_clk(sys_clk), .fire(fire), .lim(lim), .sync_pin(sync_pin),
    .dlim_pos_pin(dlim_pos_pin));
  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge sys_clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk); penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  // Reads the status word and compares it.
  task rs(input [15:0] e);
    apb(0, `SMO_OFF_STATUS, 0); `CHK(rd[15:0], e)
  endtask
  // Waits, bounded, for a velocity command value.
  task wv(input [31:0] e);
    n = 0; while (vel_cmd_q !== e && n < 2000) begin @(posedge sys_clk); n++; end
    `CHK(vel_cmd_q, e)
  endtask
  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Clock at 50 ns.
  initial begin sys_clk = 0; forever #25 sys_clk = ~sys_clk; end
  // Watchdog cuts a hang short.
  initial begin #(50*40000); fail_count++; $display("mismatch %0t watchdog", $time); stop_test; end
  // Main sequence.
  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pos_fb = 0;
    fire = 0; lim = 0; fail_count = 0; checked = 0; n = $urandom(32'h9a132752);
    vel_fb = $urandom;
    repeat (20) @(posedge sys_clk); rst_n <= 1;
    foreach (map_q[i]) begin apb(0, 8'(`SMO_OFF_MAP_BASE + 4*i), 0); `CHK(rd, map_q[i]) end
    apb(0, `SMO_OFF_VEL_ACT, 0); `CHK(rd, vel_fb)
    apb(1, 8'h60, 0); `CHK(er, 1'b1)
    apb(1, 8'h80, 1); `CHK(er, 1'b1)
    apb(0, `SMO_OFF_IP_TIDX, 0); `CHK(rd[7:0], 8'hfd)
    apb(1, `SMO_OFF_IP_TIDX, 32'hfe); apb(1, `SMO_OFF_IP_TIDX, 32'h05);
    apb(0, `SMO_OFF_IP_TIDX, 0); `CHK(rd[7:0], 8'hfe)
    apb(1, `SMO_OFF_IP_TCONST, 10); apb(0, `SMO_OFF_IP_TCONST, 0); `CHK(rd[7:0], 8'd10)
    apb(1, `SMO_OFF_MODE, 7); apb(0, `SMO_OFF_MODE_DISP, 0); `CHK(rd[7:0], 8'h07)
    apb(1, `SMO_OFF_CTRL, 6); rs(16'h0231);
    apb(1, `SMO_OFF_CTRL, 7); rs(16'h0233);
    apb(1, `SMO_OFF_CTRL, 15); rs(16'h0637);
    apb(1, `SMO_OFF_CTRL, 31); rs(16'h1637); `CHK(ip_active_q, 1'b1)
    // Two absolute targets, SYNC at least 1 ms apart; updates land one period apart.
    repeat (2) begin
      repeat (MS) @(posedge sys_clk);
      tgt = ($urandom & 32'h00ffff00) | 32'h100;
      apb(1, `SMO_OFF_IP_POS, tgt); fire <= 1; @(posedge sys_clk); fire <= 0;
      n = 0; while (pos_cmd_q !== tgt && n < 30*MS) begin @(posedge sys_clk); n++; end
      `CHK(pos_cmd_q, tgt)
      if (t0 != 0) `CHK($time - t0, 10*MS*`SMO_CLK_NS)
      t0 = $time;
    end
    rs(16'h1237);
    apb(1, `SMO_OFF_POS_WTIME, 2); pos_fb <= tgt; repeat (4) @(posedge sys_clk);
    rs(16'h1237); repeat (3*MS) @(posedge sys_clk); rs(16'h1637);
    lim <= 1; repeat (8) @(posedge sys_clk); `CHK({overtravel_q, motor_stop_q}, 2'b11)
    lim <= 0; repeat (8) @(posedge sys_clk);
    // Velocity profile with clamps and conversion.
    apb(1, `SMO_OFF_CTRL, 15); apb(1, `SMO_OFF_MODE, 3); apb(1, `SMO_OFF_MAX_ACC, 32'h100);
    apb(1, `SMO_OFF_TGT_VEL, 32'h800); wv(32'h100);
    wv(32'h600);
    apb(1, `SMO_OFF_MAX_VEL, 32'h400); wv(32'h400);
    apb(1, `SMO_OFF_CONV, 32'h200); wv(32'h800);
    // Software limit: off until enabled, then stop and flag, reverse clears.
    apb(1, `SMO_OFF_MAX_LIM, 32'h10); repeat (4) @(posedge sys_clk); `CHK(overtravel_q, 1'b0)
    apb(1, `SMO_OFF_SWL_EN, 1); wv(0); rs(16'h0e37); `CHK(overtravel_q, 1'b1)
    pos_fb <= 8; apb(1, `SMO_OFF_TGT_VEL, 32'hffffff00); repeat (4) @(posedge sys_clk);
    rs(16'h0237);
    stop_test;
  end
endmodule
